// ---- include/hsc_pkg.sv ----
/*
 * Shared constants and types of the heatseal configuration and supervision block:
 * register offsets, field layouts, reset values, fault codes and timing figures.
 * Assumes a 200 MHz pclk and temperatures carried internally in whole degrees Celsius.
 */
package hsc_pkg;
    localparam int          TW          = 12;
    // Register byte offsets
    localparam logic [7:0]  CTRL_OFF    = 8'h00;
    localparam logic [7:0]  SETPT_OFF   = 8'h04;
    localparam logic [7:0]  MAXT_OFF    = 8'h08;
    localparam logic [7:0]  TOL_OFF     = 8'h0c;
    localparam logic [7:0]  DLY_OFF     = 8'h10;
    localparam logic [7:0]  HEATUP_OFF  = 8'h14;
    localparam logic [7:0]  MEAS_OFF    = 8'h18;
    localparam logic [7:0]  CYCLES_OFF  = 8'h1c;
    localparam logic [7:0]  STATUS_OFF  = 8'h20;
    localparam logic [7:0]  MASK_OFF    = 8'h24;
    localparam logic [7:0]  ACTUAL_OFF  = 8'h28;
    // Field positions
    localparam int          TOL_HI_POS  = 16;
    localparam int          ST_DIAG     = 0;
    localparam int          ST_HEATUP   = 1;
    localparam int          ST_REFUSE   = 2;
    localparam int          BAR_POS     = 16;
    // Reset values
    localparam logic [7:0]  CTRL_RST    = 8'h81;
    localparam logic [TW-1:0] SETPT_RST = 12'h000;
    localparam logic [TW-1:0] MAXT_RST  = 12'h1f4;
    localparam logic [TW-1:0] TOL_RST   = 12'h00a;
    localparam logic [9:0]  TIME_RST    = 10'h000;
    localparam logic [4:0]  MEAS_RST    = 5'h11;
    localparam logic [2:0]  MASK_RST    = 3'h0;
    // Limits and codes
    localparam logic [4:0]  MEAS_MIN    = 5'h11;
    localparam logic [4:0]  MEAS_MAX    = 5'h1e;
    localparam logic [9:0]  TIME_MAX    = 10'h3e7;
    localparam logic [TW-1:0] MIN_HEAT_C = 12'h028;
    localparam logic [29:0] CNT_MAX     = 30'h3b9ac9ff;
    localparam logic [TW-1:0] FC_NONE   = 12'h000;
    localparam logic [TW-1:0] FC_HEATUP = 12'h130;
    localparam logic [TW-1:0] FC_LOW    = 12'h133;
    localparam logic [TW-1:0] FC_HIGH   = 12'h134;
    // Timing: time base of the 0.1 s settings and of the 0.1 ms impulse steps
    localparam int          CLK_PS      = 5000;
    localparam int          TICK_US     = 100000;
    localparam int          SUB_US      = 100;
    localparam int          TICK_CYC    = TICK_US * 1000 / CLK_PS * 1000;
    localparam int          SUB_CYC     = SUB_US * 1000 * 1000 / CLK_PS;

    typedef enum logic [1:0] {
        RNG_200 = 2'b00,
        RNG_300 = 2'b01,
        RNG_400 = 2'b10,
        RNG_500 = 2'b11
    } hsc_range_type;

    typedef enum logic [1:0] {
        HS_IDLE   = 2'b00,
        HS_START  = 2'b01,
        HS_MANUAL = 2'b10
    } hsc_heat_type;

    typedef struct packed {
        logic          heatup_off;
        logic          fahr;
        logic          phase_comp;
        logic          diag_en;
        logic          alarm_inv;
        logic          lock;
        hsc_range_type range;
    } hsc_cfg_type;

    typedef struct packed {
        logic          set_valid;
        logic [TW-1:0] setpoint;
        logic [TW-1:0] actual;
        logic [7:0]    bar;
    } hsc_disp_type;
endpackage

// ---- hw/hsc_top.sv ----
/*
 * Configuration and supervision of an impulse heatseal temperature controller,
 * with an APB register slave, heating decision, cycle counter, band diagnosis,
 * heat-up timeout, measuring impulse timing and display values.
 * Assumes start, keys and the measured temperature are synchronous to pclk.
 */
// Our own choices: register access over APB and the address map.
`timescale 1ns/100ps
module hsc_top
#(
    parameter int TICK_CYCLES = hsc_pkg::TICK_CYC,
    parameter int SUB_CYCLES  = hsc_pkg::SUB_CYC
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  start_in,
    input  wire logic                  manual_heat_key,
    input  wire logic                  home_display,
    input  wire logic                  counter_reset_key,
    input  wire logic                  factory_restore,
    input  wire logic [hsc_pkg::TW-1:0] actual_temp,
    output logic                       heat_en_q,
    output logic                       alarm_relay_q,
    output logic [hsc_pkg::TW-1:0]     fault_code_q,
    output logic                       irq_q,
    output logic                       meas_pulse_q,
    output logic                       phase_comp_en_q,
    output hsc_pkg::hsc_disp_type      disp_q
);
    import hsc_pkg::*;

    hsc_cfg_type   cfg_q;
    hsc_heat_type  state_q, state_d;
    logic [TW-1:0] setpt_q, maxt_q, tol_lo_q, tol_hi_q, sp_eff, top_c, lim, band_lo, band_hi;
    logic [9:0]    dly_q, heatup_q, dly_cnt_q, hu_cnt_q;
    logic [4:0]    meas_q, meas_cnt_q;
    logic [29:0]   cycles_q;
    logic [2:0]    status_q, mask_q, ev;
    logic [31:0]   tick_cnt_q, sub_cnt_q, rdata_d, prdata_q;
    logic          pready_q, pslverr_q, start_prev_q, key_prev_q, band_prev_q;
    logic          armed_q, counting_q, hu_run_q, hu_fault_q, diag_prev_q;
    logic          tick, sub_tick, wr_fire, rd_fire, setup, mapped, allowed, start_rise;
    logic          manual_ok, inc, clr, in_band, diag_fault, hu_expire;
    logic [TW-1:0] wval_c, fault_d;

    function automatic logic [TW-1:0] to_f(input logic [TW-1:0] c);
        logic [15:0] t;
        t = 16'(c) * 16'h9;
        return 12'(t / 16'h5 + 16'h20);
    endfunction

    function automatic logic [TW-1:0] to_c(input logic [TW-1:0] f);
        logic [15:0] t;
        t = (f < 12'h020) ? 16'h0 : 16'(f - 12'h020) * 16'h5;
        return 12'(t / 16'h9);
    endfunction

    // Range top and set point limit
    always_comb begin
        unique case (cfg_q.range)
            RNG_200: top_c = 12'h0c8;
            RNG_300: top_c = 12'h12c;
            RNG_400: top_c = 12'h190;
            RNG_500: top_c = 12'h1f4;
        endcase
    end
    assign lim     = (maxt_q < top_c) ? maxt_q : top_c;
    assign sp_eff  = (setpt_q < lim) ? setpt_q : lim;
    assign band_lo = (sp_eff > tol_lo_q) ? sp_eff - tol_lo_q : 12'h000;
    assign band_hi = sp_eff + tol_hi_q;
    assign in_band = actual_temp >= band_lo && actual_temp <= band_hi;
    assign wval_c  = cfg_q.fahr ? to_c(pwdata[TW-1:0]) : pwdata[TW-1:0];

    // APB slave: one wait state, so read data is registered before pready
    assign setup   = psel && penable && !pready_q;
    assign wr_fire = psel && penable && pready_q && pwrite;
    assign rd_fire = psel && penable && pready_q && !pwrite;
    assign mapped  = paddr <= ACTUAL_OFF && paddr[1:0] == 2'b00;

    always_comb begin
        rdata_d = 32'h0;
        unique case (paddr)
            CTRL_OFF:   rdata_d = 32'(cfg_q);
            SETPT_OFF:  rdata_d = 32'(cfg_q.fahr ? to_f(sp_eff) : sp_eff);
            MAXT_OFF:   rdata_d = 32'(cfg_q.fahr ? to_f(maxt_q) : maxt_q);
            TOL_OFF:    rdata_d = {4'h0, tol_hi_q, 4'h0, tol_lo_q};
            DLY_OFF:    rdata_d = 32'(dly_q);
            HEATUP_OFF: rdata_d = 32'(heatup_q);
            MEAS_OFF:   rdata_d = 32'(meas_q);
            CYCLES_OFF: rdata_d = 32'(cycles_q);
            STATUS_OFF: rdata_d = 32'(status_q);
            MASK_OFF:   rdata_d = 32'(mask_q);
            ACTUAL_OFF: rdata_d = {8'h0, disp_q.bar, 4'h0, disp_q.actual};
            default:    rdata_d = 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !mapped;
            if (setup) begin
                prdata_q <= rdata_d;
            end
        end
    end
    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // Configuration registers; factory restore reloads every default
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q    <= hsc_cfg_type'(CTRL_RST);
            setpt_q  <= SETPT_RST;
            maxt_q   <= MAXT_RST;
            tol_lo_q <= TOL_RST;
            tol_hi_q <= TOL_RST;
            dly_q    <= TIME_RST;
            heatup_q <= TIME_RST;
            meas_q   <= MEAS_RST;
            mask_q   <= MASK_RST;
        end else if (factory_restore) begin
            cfg_q    <= hsc_cfg_type'(CTRL_RST);
            setpt_q  <= SETPT_RST;
            maxt_q   <= MAXT_RST;
            tol_lo_q <= TOL_RST;
            tol_hi_q <= TOL_RST;
            dly_q    <= TIME_RST;
            heatup_q <= TIME_RST;
            meas_q   <= MEAS_RST;
            mask_q   <= MASK_RST;
        end else if (wr_fire) begin
            unique case (paddr)
                CTRL_OFF:   cfg_q <= hsc_cfg_type'(pwdata[7:0]);
                SETPT_OFF:  setpt_q <= (wval_c < lim) ? wval_c : lim;
                MAXT_OFF:   maxt_q <= (wval_c < top_c) ? wval_c : top_c;
                TOL_OFF: begin
                    tol_lo_q <= pwdata[TW-1:0];
                    tol_hi_q <= pwdata[TOL_HI_POS +: TW];
                end
                DLY_OFF:    if (cfg_q.diag_en) dly_q <= (pwdata[9:0] > TIME_MAX) ?
                                TIME_MAX : pwdata[9:0];
                HEATUP_OFF: heatup_q <= (pwdata[9:0] > TIME_MAX) ? TIME_MAX : pwdata[9:0];
                MEAS_OFF:   meas_q <= (pwdata[4:0] < MEAS_MIN) ? MEAS_MIN :
                                      (pwdata[4:0] > MEAS_MAX) ? MEAS_MAX : pwdata[4:0];
                MASK_OFF:   mask_q <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // Heating decision
    assign allowed    = sp_eff > MIN_HEAT_C;
    assign start_rise = start_in && !start_prev_q;
    assign manual_ok  = manual_heat_key && home_display && !cfg_q.lock;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            HS_IDLE: begin
                if (start_rise && allowed) begin
                    state_d = HS_START;
                end else if (manual_ok && allowed) begin
                    state_d = HS_MANUAL;
                end
            end
            HS_START: begin
                if (!start_in || !allowed) begin
                    state_d = HS_IDLE;
                end
            end
            HS_MANUAL: begin
                if (start_rise && allowed) begin
                    state_d = HS_START;
                end else if (!manual_heat_key || cfg_q.lock || !allowed) begin
                    state_d = HS_IDLE;
                end
            end
            default: state_d = HS_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q      <= HS_IDLE;
            heat_en_q    <= 1'b0;
            start_prev_q <= 1'b0;
            key_prev_q   <= 1'b0;
        end else begin
            state_q      <= state_d;
            heat_en_q    <= state_d != HS_IDLE;
            start_prev_q <= start_in;
            key_prev_q   <= manual_ok;
        end
    end

    // Cycle counter; a clear in the same cycle as a count leaves one
    assign inc = start_rise && allowed;
    assign clr = counter_reset_key || factory_restore || (wr_fire && paddr == CYCLES_OFF);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycles_q <= 30'h0;
        end else if (inc || clr) begin
            cycles_q <= clr ? 30'(inc) :
                        (cycles_q == CNT_MAX) ? 30'h0 : cycles_q + 30'h1;
        end
    end

    // Time bases: 0.1 s tick and 0.1 ms step
    assign tick     = tick_cnt_q == 32'(TICK_CYCLES - 1);
    assign sub_tick = sub_cnt_q == 32'(SUB_CYCLES - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= 32'h0;
            sub_cnt_q  <= 32'h0;
        end else begin
            tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
            sub_cnt_q  <= sub_tick ? 32'h0 : sub_cnt_q + 32'h1;
        end
    end

    // Measuring impulse: once per tick while idle, length in 0.1 ms steps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meas_pulse_q <= 1'b0;
            meas_cnt_q   <= 5'h0;
        end else if (tick && state_q == HS_IDLE && !meas_pulse_q) begin
            meas_pulse_q <= 1'b1;
            meas_cnt_q   <= meas_q;
        end else if (meas_pulse_q && sub_tick) begin
            meas_cnt_q <= meas_cnt_q - 5'h1;
            if (meas_cnt_q == 5'h1) begin
                meas_pulse_q <= 1'b0;
            end
        end
    end

    // Band diagnosis with entry delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            band_prev_q <= 1'b0;
            counting_q  <= 1'b0;
            armed_q     <= 1'b0;
            dly_cnt_q   <= 10'h0;
        end else begin
            band_prev_q <= in_band;
            if (!cfg_q.diag_en) begin
                counting_q <= 1'b0;
                armed_q    <= 1'b0;
            end else if (in_band && !band_prev_q) begin
                counting_q <= 1'b1;
                armed_q    <= 1'b0;
                dly_cnt_q  <= dly_q;
            end else if (counting_q && (dly_cnt_q == 10'h0)) begin
                counting_q <= 1'b0;
                armed_q    <= 1'b1;
            end else if (counting_q && tick) begin
                dly_cnt_q <= dly_cnt_q - 10'h1;
            end
        end
    end
    assign diag_fault = cfg_q.diag_en && armed_q && !in_band;

    // Heat-up timeout, measured from start activation
    assign hu_expire = hu_run_q && hu_cnt_q == 10'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hu_run_q   <= 1'b0;
            hu_cnt_q   <= 10'h0;
            hu_fault_q <= 1'b0;
        end else if (inc && !cfg_q.heatup_off) begin
            hu_run_q   <= 1'b1;
            hu_cnt_q   <= heatup_q;
            hu_fault_q <= 1'b0;
        end else if (hu_expire) begin
            hu_run_q   <= 1'b0;
            hu_fault_q <= !in_band;
        end else if (hu_run_q && tick) begin
            hu_cnt_q <= hu_cnt_q - 10'h1;
        end
    end

    // Fault code and alarm relay; the heat-up fault outranks the band fault
    assign fault_d = hu_fault_q ? FC_HEATUP :
                     !diag_fault ? FC_NONE :
                     (actual_temp < band_lo) ? FC_LOW : FC_HIGH;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_code_q    <= FC_NONE;
            alarm_relay_q   <= 1'b0;
            phase_comp_en_q <= 1'b0;
            diag_prev_q     <= 1'b0;
        end else begin
            fault_code_q    <= fault_d;
            alarm_relay_q   <= (fault_d != FC_NONE) ^ cfg_q.alarm_inv;
            phase_comp_en_q <= cfg_q.phase_comp;
            diag_prev_q     <= diag_fault;
        end
    end

    // Sticky events; a set in the clearing read cycle survives
    assign ev = {(start_rise || (manual_ok && !key_prev_q)) && !allowed,
                 hu_expire && !in_band, diag_fault && !diag_prev_q};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= 3'h0;
            irq_q    <= 1'b0;
        end else begin
            status_q <= (rd_fire && paddr == STATUS_OFF) ? ev : (status_q | ev);
            irq_q    <= |(status_q & mask_q);
        end
    end

    // Display values in the selected unit; bar spans the selected range
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disp_q <= '0;
        end else begin
            disp_q.actual   <= cfg_q.fahr ? to_f(actual_temp) : actual_temp;
            disp_q.bar      <= 8'((20'(actual_temp < top_c ? actual_temp : top_c) * 20'hff)
                               / 20'(top_c));
            disp_q.setpoint <= cfg_q.fahr ? to_f(sp_eff) : sp_eff;
            disp_q.set_valid <= !factory_restore &&
                                (disp_q.set_valid || (wr_fire && paddr == SETPT_OFF));
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    min_setpoint_a: assert property (heat_en_q |-> $past(sp_eff) > MIN_HEAT_C)
        else $error("heating with set point not above 40");
    lock_manual_a: assert property (state_q == HS_MANUAL |-> !$past(cfg_q.lock))
        else $error("manual heating while locked");
    count_start_a: assert property (inc && !clr && cycles_q != CNT_MAX
        |=> cycles_q == $past(cycles_q) + 30'h1)
        else $error("start impulse not counted");
    no_manual_count_a: assert property (!inc && !clr |=> $stable(cycles_q))
        else $error("counter moved without start");
    count_clear_a: assert property (clr && !inc |=> cycles_q == 30'h0)
        else $error("counter not cleared");
    count_wrap_a: assert property (inc && !clr && cycles_q == CNT_MAX |=> cycles_q == 30'h0)
        else $error("counter did not wrap");
    relay_polarity_a: assert property (##1 alarm_relay_q
        == ((fault_code_q != FC_NONE) ^ $past(cfg_q.alarm_inv)))
        else $error("alarm relay polarity wrong");
    diag_code_a: assert property (fault_code_q == FC_LOW || fault_code_q == FC_HIGH
        |-> $past(cfg_q.diag_en) && !$past(in_band))
        else $error("diagnosis fault without cause");
    manual_release_a: assert property (state_q == HS_MANUAL && !manual_heat_key && !start_rise
        |=> !heat_en_q)
        else $error("manual heat outlived key");
    apb_answer_a: assert property (setup |=> pready_q ##1 !pready_q)
        else $error("apb answer timing wrong");

    start_heat_c: cover property (inc ##1 heat_en_q [*3]);
    manual_heat_c: cover property (state_q == HS_MANUAL ##1 state_q == HS_IDLE);
    heatup_fault_c: cover property (fault_code_q == FC_HEATUP && irq_q);
endmodule

// ---- bench/hsc_machine.sv ----
/*
 * Machine control and operator model for hsc_top: start line, keys,
 * display position and the measured band temperature.
 * Assumes the bench calls its tasks; every change lands just after a pclk edge.
 */
`timescale 1ns/100ps
module hsc_machine (
    input  wire logic          pclk,
    output logic               start_in,
    output logic               manual_heat_key,
    output logic               home_display,
    output logic               counter_reset_key,
    output logic               factory_restore,
    output logic [11:0]        actual_temp
);
    initial begin
        start_in = 1'b0;
        manual_heat_key = 1'b0;
        home_display = 1'b0;
        counter_reset_key = 1'b0;
        factory_restore = 1'b0;
        actual_temp = 12'h014;
    end
    // Levels are held until the next call, as a real operator would
    task act(input logic s, input logic k, input logic h, input logic c);
        @(posedge pclk);
        start_in <= s;
        manual_heat_key <= k;
        home_display <= h;
        counter_reset_key <= c;
    endtask
    task restore;
        @(posedge pclk);
        factory_restore <= 1'b1;
        @(posedge pclk);
        factory_restore <= 1'b0;
    endtask
    task set_temp(input logic [11:0] t);
        @(posedge pclk);
        actual_temp <= t;
    endtask
endmodule

// ---- bench/tb_top.sv ----
/*
 * Self-checking bench for hsc_top with APB tasks and one task per scenario.
 * Assumes hsc_machine drives start, keys and temperature; short tick counts.
 */
`timescale 1ns/100ps
module tb_top;
    import hsc_pkg::*;
    localparam int SUB = 4;
    logic          pclk;
    logic          presetn;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [7:0]    paddr;
    logic [31:0]   pwdata;
    logic [31:0]   prdata, rd;
    logic          pready, pslverr, err, heat, relay, irq, pce, mp, s, k, h, c, f;
    logic [TW-1:0] fault, t;
    hsc_disp_type  disp;
    int            n_errors = 0;
    int            cmp_count = 0;
    int            cyc = 0;
    always #2.5 pclk = ~pclk;
    hsc_top #(.TICK_CYCLES(20), .SUB_CYCLES(SUB)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .start_in(s),
        .manual_heat_key(k), .home_display(h), .counter_reset_key(c),
        .factory_restore(f), .actual_temp(t), .heat_en_q(heat), .alarm_relay_q(relay),
        .fault_code_q(fault), .irq_q(irq), .meas_pulse_q(mp), .phase_comp_en_q(pce),
        .disp_q(disp));
    hsc_machine m (.pclk(pclk), .start_in(s), .manual_heat_key(k), .home_display(h),
        .counter_reset_key(c), .factory_restore(f), .actual_temp(t));
    task wrap_up;
        $display("tests done: %0d compares, %0d errors", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Hang guard, well above the few hundred cycles the scenarios need
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            wrap_up;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task w(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task t_meas;
        int n;
        n = 0;
        do @(posedge pclk); while (mp !== 1'b1);
        while (mp === 1'b1) begin
            n++;
            @(posedge pclk);
        end
        chk(n > (MEAS_RST - 1) * SUB && n <= MEAS_RST * SUB, 1);
        apb(1, MEAS_OFF, 32'h1f);
        apb(0, MEAS_OFF, 0); chk(rd, 32'h1e);
        apb(1, MEAS_OFF, 32'h1);
        apb(0, MEAS_OFF, 0); chk(rd, 32'h11);
        $display("test meas done");
    endtask
    task t_regs;
        apb(0, CTRL_OFF, 0); chk(rd, 32'h81);
        apb(0, MAXT_OFF, 0); chk(rd, 32'h1f4);
        apb(0, 8'h2c, 0); chk(err, 1);
        apb(1, CTRL_OFF, 32'h83);
        apb(1, MAXT_OFF, 32'h12c);
        apb(1, SETPT_OFF, 32'h1f4);
        apb(0, SETPT_OFF, 0); chk(rd, 32'h12c);
        apb(1, CTRL_OFF, 32'h80);
        apb(0, SETPT_OFF, 0); chk(rd, 32'hc8);
        apb(1, CTRL_OFF, 32'h83);
        $display("test regs done");
    endtask
    task t_refuse;
        apb(1, SETPT_OFF, 32'h28);
        apb(1, MASK_OFF, 32'h4);
        m.act(1, 0, 0, 0); w(3); chk(heat, 0);
        chk(irq, 1);
        apb(0, STATUS_OFF, 0); chk(rd, 32'h4);
        m.act(0, 1, 1, 0); w(3); chk(heat, 0);
        m.act(0, 0, 0, 0);
        $display("test refuse done");
    endtask
    task t_count;
        apb(1, SETPT_OFF, 32'h64);
        apb(1, CYCLES_OFF, 0);
        m.act(1, 0, 0, 0); w(3); chk(heat, 1);
        apb(0, CYCLES_OFF, 0); chk(rd, 1);
        m.act(0, 1, 1, 0); w(3); chk(heat, 1);
        m.act(0, 0, 1, 0); w(3); chk(heat, 0);
        apb(0, CYCLES_OFF, 0); chk(rd, 1);
        apb(1, CTRL_OFF, 32'h87);
        m.act(0, 1, 1, 0); w(3); chk(heat, 0);
        m.act(0, 0, 0, 1); w(2);
        m.act(0, 0, 0, 0);
        apb(0, CYCLES_OFF, 0); chk(rd, 0);
        $display("test count done");
    endtask
    task t_disp;
        chk(disp.set_valid, 1);
        chk(disp.setpoint, 12'h064);
        chk(disp.actual, 12'h014);
        apb(1, CTRL_OFF, 32'he3); w(2);
        chk(pce, 1);
        apb(0, SETPT_OFF, 0); chk(rd, 32'hd4);
        $display("test display done");
    endtask
    task t_diag;
        apb(1, CTRL_OFF, 32'h83);
        apb(1, DLY_OFF, 32'h5);
        apb(1, CTRL_OFF, 32'h93);
        apb(0, DLY_OFF, 0); chk(rd, 0);
        apb(1, DLY_OFF, 32'h2);
        m.set_temp(12'h064); w(5);
        m.set_temp(12'h0c8); w(3); chk(fault, FC_NONE);
        m.set_temp(12'h064); w(60);
        m.set_temp(12'h0c8); w(3); chk(fault, FC_HIGH);
        chk(relay, 1);
        m.set_temp(12'h032); w(3); chk(fault, FC_LOW);
        apb(1, CTRL_OFF, 32'h9b); w(3); chk(relay, 0);
        $display("test diag done");
    endtask
    task t_heatup;
        apb(1, CTRL_OFF, 32'h03);
        apb(1, HEATUP_OFF, 32'h1);
        m.set_temp(12'h0c8);
        m.act(1, 0, 0, 0); w(80); chk(fault, FC_HEATUP);
        m.act(0, 0, 0, 0);
        m.restore;
        apb(0, CYCLES_OFF, 0); chk(rd, 0);
        apb(0, CTRL_OFF, 0); chk(rd, 32'h81);
        chk(disp.set_valid, 0);
        $display("test heatup done");
    endtask
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        w(4);
        presetn <= 1'b1;
        t_meas;
        t_regs;
        t_refuse;
        t_count;
        t_disp;
        t_diag;
        t_heatup;
        wrap_up;
    end
endmodule
